//--- rtl/charge_time_unit.sv
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/10ps
// Overview of operation
// - Current range held in control bits 1:0
// - Current trim held in control bits 7:2
// - Edge source selects at 3:2 and 6:5
// - Edge polarity bits at 4 and 7
// - Both edges negative-going after reset
// - Edge ordering enable bit 2, reset clear
// - Mode bit; reset selects measurement
// - Discharge bit 1 discharges while set
// - Unit enable bit 7 gates edge arming and the current source
// - Edge flags bits 1:0, software clears
// - Edge inputs enable bit 3 arms detection
// - Sources include timer and compare/PWM unit
// - Converter samples after charge in measurement
// - Second comparator ends delay pulses
// - Source on when exactly one flag set
// - Software writes set flags directly
// - Interrupt flag on source on then off
module charge_time_unit (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Edge sources
  input wire logic first_edge_pin,
  input wire logic second_edge_pin,
  input wire logic first_timer_out,
  input wire logic compare_pwm_out,
  input wire logic comparator2_out,
  // Analog controls
  output logic current_source_on,
  output logic [1:0] current_range_sel,
  output logic [5:0] current_trim,
  output logic discharge_on,
  output logic delay_pulse_out,
  output logic adc_sample_start,
  // Interrupt request to the core
  output logic irq_request
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] current_source_control;
  logic [7:0] edge_config_low;
  logic [7:0] unit_control_high;
  logic unit_irq_flag;
  logic unit_irq_enable;
  logic [1:0] edge_flags;
  logic [1:0] next_edge_flags;
  logic next_unit_irq_flag;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;

  // Pins are asynchronous to the clock; only pin_sync is read by logic
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= {comparator2_out, second_edge_pin, first_edge_pin};
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire wr_icon = reg_wr && (reg_addr == ctu_pkg::OFF_CURRENT_SOURCE_CONTROL);
  wire wr_low = reg_wr && (reg_addr == ctu_pkg::OFF_EDGE_CONFIG_LOW);
  wire wr_high = reg_wr && (reg_addr == ctu_pkg::OFF_UNIT_CONTROL_HIGH);
  wire wr_pflag = reg_wr && (reg_addr == ctu_pkg::OFF_PERIPHERAL_FLAG_REG);
  wire wr_pen = reg_wr && (reg_addr == ctu_pkg::OFF_PERIPHERAL_ENABLE_REG);

  // Control fields
  wire [1:0] first_edge_source = edge_config_low[ctu_pkg::FIRST_SRC_LSB +: ctu_pkg::SRC_W];
  wire [1:0] second_edge_source = edge_config_low[ctu_pkg::SECOND_SRC_LSB +: ctu_pkg::SRC_W];
  wire first_edge_polarity = edge_config_low[ctu_pkg::FIRST_POL_BIT];
  wire second_edge_polarity = edge_config_low[ctu_pkg::SECOND_POL_BIT];
  wire discharge_control = unit_control_high[ctu_pkg::DISCHARGE_BIT];
  wire edge_order_enable = unit_control_high[ctu_pkg::ORDER_EN_BIT];
  wire edge_inputs_enable = unit_control_high[ctu_pkg::EDGES_EN_BIT];
  wire delay_mode_select = unit_control_high[ctu_pkg::DELAY_MODE_BIT];
  wire unit_enable = unit_control_high[ctu_pkg::UNIT_EN_BIT];
  wire first_edge_flag = edge_flags[0];
  wire second_edge_flag = edge_flags[1];

  // ----------------------------------------
  // Edge detection, one detector per edge
  // ----------------------------------------
  logic [1:0] edge_event;
  wire [1:0] edge_sel [2];
  wire edge_pol [2];
  wire [3:0] edge_sources [2];
  assign edge_sel[0] = first_edge_source;
  assign edge_sel[1] = second_edge_source;
  assign edge_pol[0] = first_edge_polarity;
  assign edge_pol[1] = second_edge_polarity;
  // Code order: own pin, timer, compare/PWM unit, other edge's pin
  assign edge_sources[0] = {pin_sync[1], compare_pwm_out, first_timer_out, pin_sync[0]};
  assign edge_sources[1] = {pin_sync[0], compare_pwm_out, first_timer_out, pin_sync[1]};

  generate
    for (genvar i = 0; i < 2; i++) begin : g_edge
      edge_detect u_edge (
        .clock(clock),
        .srst(srst),
        .sources(edge_sources[i]),
        .source_sel(edge_sel[i]),
        .polarity(edge_pol[i]),
        .edge_event(edge_event[i])
      );
    end
  endgenerate

  // Comparator 2 rising edge ends the pulse in delay mode
  logic comp_prev;
  always_ff @(posedge clock) begin
    if (srst) begin
      comp_prev <= 1'b0;
    end else begin
      comp_prev <= pin_sync[2];
    end
  end
  wire comp_rise = pin_sync[2] & ~comp_prev;

  // ----------------------------------------
  // Edge flag set logic
  // ----------------------------------------
  wire armed = unit_enable & edge_inputs_enable;
  wire first_set = armed & edge_event[0];
  wire second_raw = edge_event[1] | (delay_mode_select & comp_rise);
  // With ordering on, a second edge before the first is dropped, not held
  wire second_set = armed & second_raw & (~edge_order_enable | first_edge_flag);
  wire [1:0] flag_set = {second_set, first_set};
  // A hardware set wins over a software clear in the same cycle
  assign next_edge_flags = (wr_low ? reg_wdata[1:0] : edge_flags) | flag_set;

  // Exactly one flag drives the source
  wire source_cond = unit_enable & (first_edge_flag ^ second_edge_flag);
  wire source_off_event = current_source_on & ~source_cond;
  assign next_unit_irq_flag = (wr_pflag ? reg_wdata[ctu_pkg::UNIT_IRQ_BIT] : unit_irq_flag) | source_off_event;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      current_source_control <= ctu_pkg::RST_CURRENT_SOURCE_CONTROL;
      unit_control_high <= ctu_pkg::RST_UNIT_CONTROL_HIGH;
    end else begin
      if (wr_icon) begin
        current_source_control <= reg_wdata;
      end
      if (wr_high) begin
        unit_control_high <= reg_wdata & 8'h9E;
      end
    end
  end

  // Edge configuration, flags kept apart from the config bits
  always_ff @(posedge clock) begin
    if (srst) begin
      edge_config_low <= ctu_pkg::RST_EDGE_CONFIG_LOW;
      edge_flags <= 2'h0;
    end else begin
      if (wr_low) begin
        edge_config_low <= {reg_wdata[7:2], 2'h0};
      end
      edge_flags <= next_edge_flags;
    end
  end

  // Interrupt flag and enable
  always_ff @(posedge clock) begin
    if (srst) begin
      unit_irq_flag <= 1'b0;
      unit_irq_enable <= 1'b0;
    end else begin
      unit_irq_flag <= next_unit_irq_flag;
      if (wr_pen) begin
        unit_irq_enable <= reg_wdata[ctu_pkg::UNIT_IRQ_BIT];
      end
    end
  end

  // ----------------------------------------
  // Outputs to the analog side
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      current_source_on <= 1'b0;
      current_range_sel <= 2'h0;
      current_trim <= 6'h00;
      discharge_on <= 1'b0;
      delay_pulse_out <= 1'b0;
      adc_sample_start <= 1'b0;
      irq_request <= 1'b0;
    end else begin
      current_source_on <= source_cond;
      current_range_sel <= current_source_control[ctu_pkg::RANGE_LSB +: ctu_pkg::RANGE_W];
      current_trim <= current_source_control[ctu_pkg::TRIM_LSB +: ctu_pkg::TRIM_W];
      discharge_on <= discharge_control;
      delay_pulse_out <= source_cond & delay_mode_select;
      // Converter samples once the charge interval has ended
      adc_sample_start <= source_off_event & ~delay_mode_select;
      irq_request <= next_unit_irq_flag & unit_irq_enable;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] read_mux;
  always_comb begin
    unique case (reg_addr)
      ctu_pkg::OFF_CURRENT_SOURCE_CONTROL: read_mux = current_source_control;
      ctu_pkg::OFF_EDGE_CONFIG_LOW: read_mux = {edge_config_low[7:2], edge_flags};
      ctu_pkg::OFF_UNIT_CONTROL_HIGH: read_mux = unit_control_high;
      ctu_pkg::OFF_PERIPHERAL_FLAG_REG: read_mux = {5'h00, unit_irq_flag, 2'h0};
      ctu_pkg::OFF_PERIPHERAL_ENABLE_REG: read_mux = {5'h00, unit_irq_enable, 2'h0};
      default: read_mux = 8'h00;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? read_mux : 8'h00;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  range_write_a: assert property (wr_icon |=> ##1 current_range_sel == $past(reg_wdata[1:0], 2))
    else $error("current range not taken from write");
  trim_write_a: assert property (wr_icon |=> ##1 current_trim == $past(reg_wdata[7:2], 2))
    else $error("current trim not taken from write");
  source_select_a: assert property (wr_low |=> second_edge_source == $past(reg_wdata[6:5]))
    else $error("second edge source not taken from write");
  // Reset checks must run while reset is high, so they opt out of the default disable
  polarity_reset_a: assert property (@(posedge clock) disable iff (1'b0) srst |=> !first_edge_polarity && !second_edge_polarity)
    else $error("polarity not negative after reset");
  order_reset_a: assert property (@(posedge clock) disable iff (1'b0) srst |=> !edge_order_enable && !delay_mode_select)
    else $error("ordering or delay mode set after reset");
  discharge_follow_a: assert property (discharge_control |=> discharge_on)
    else $error("discharge output not following control bit");
  source_exact_one_a: assert property (unit_enable && (edge_flags == 2'h3) |=> !current_source_on)
    else $error("current source on with both flags set");
  edge_flag_set_a: assert property (armed && edge_event[0] |=> first_edge_flag)
    else $error("first edge flag not set by edge");
  order_block_a: assert property (edge_order_enable && !first_edge_flag && !second_edge_flag && !wr_low
    |=> !second_edge_flag)
    else $error("second flag set before first with ordering");
  irq_on_off_a: assert property (current_source_on && !source_cond |=> unit_irq_flag)
    else $error("interrupt flag missed on source turn-off");

  measure_cycle_c: cover property (source_cond ##[1:50] !source_cond && !delay_mode_select);
  delay_pulse_c: cover property (delay_mode_select && comp_rise && armed);
  irq_raise_c: cover property (irq_request);

endmodule

//--- rtl/ctu_pkg.sv
package ctu_pkg;

  // ----------------------------------------
  // Register map (byte offsets on the 3-bit port)
  // ----------------------------------------
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFF_CURRENT_SOURCE_CONTROL = 3'h0;
  localparam logic [2:0] OFF_EDGE_CONFIG_LOW = 3'h1;
  localparam logic [2:0] OFF_UNIT_CONTROL_HIGH = 3'h2;
  localparam logic [2:0] OFF_PERIPHERAL_FLAG_REG = 3'h3;
  localparam logic [2:0] OFF_PERIPHERAL_ENABLE_REG = 3'h4;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int RANGE_LSB = 0;
  localparam int RANGE_W = 2;
  localparam int TRIM_LSB = 2;
  localparam int TRIM_W = 6;
  localparam int FIRST_FLAG_BIT = 0;
  localparam int SECOND_FLAG_BIT = 1;
  localparam int FIRST_SRC_LSB = 2;
  localparam int FIRST_POL_BIT = 4;
  localparam int SECOND_SRC_LSB = 5;
  localparam int SECOND_POL_BIT = 7;
  localparam int SRC_W = 2;
  localparam int DISCHARGE_BIT = 1;
  localparam int ORDER_EN_BIT = 2;
  localparam int EDGES_EN_BIT = 3;
  localparam int DELAY_MODE_BIT = 4;
  localparam int UNIT_EN_BIT = 7;
  localparam int UNIT_IRQ_BIT = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_CURRENT_SOURCE_CONTROL = 8'h00;
  localparam logic [7:0] RST_EDGE_CONFIG_LOW = 8'h00;
  localparam logic [7:0] RST_UNIT_CONTROL_HIGH = 8'h00;
  localparam logic RST_POLARITY_NEGATIVE = 1'b0;

  // ----------------------------------------
  // Edge source codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    SRC_OWN_PIN = 2'h0,
    SRC_FIRST_TIMER = 2'h1,
    SRC_COMPARE_PWM_UNIT = 2'h2,
    SRC_OTHER_PIN = 2'h3
  } edge_source_t;

endpackage

//--- rtl/edge_detect.sv
`timescale 1ns/10ps
module edge_detect (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Candidate sources, already in the clock domain
  input wire logic [3:0] sources,
  input wire logic [1:0] source_sel,
  input wire logic polarity,
  // Detected transition, one-cycle pulse
  output logic edge_event
);

  logic prev_level;
  logic cur_level;

  // ----------------------------------------
  // Selection and polarity
  // ----------------------------------------
  assign cur_level = sources[source_sel];
  // Polarity low means high-to-low; a change of selection may show as one edge
  assign edge_event = polarity ? (cur_level & ~prev_level) : (~cur_level & prev_level);

  // Previous level of the selected source
  always_ff @(posedge clock) begin
    if (srst) begin
      prev_level <= 1'b0;
    end else begin
      prev_level <= cur_level;
    end
  end

endmodule

//--- dv/edge_partner.sv
`timescale 1ns/10ps
// ----------------------------------------
// Edge sources facing the unit
// ----------------------------------------
module edge_partner (
  // Clock
  input wire logic clock,
  // Lines towards the unit
  output logic first_edge_pin,
  output logic second_edge_pin,
  output logic first_timer_out,
  output logic compare_pwm_out,
  output logic comparator2_out
);
  // Pins idle high, so the default falling sensitivity sees clean edges
  initial begin
    {first_edge_pin, second_edge_pin} = 2'h3;
    {first_timer_out, compare_pwm_out, comparator2_out} = 3'h0;
  end
  // Park every line; the timer level is left to the caller
  task automatic park(input logic timer_level);
    @(posedge clock);
    first_edge_pin <= 1'b1;
    second_edge_pin <= 1'b1;
    first_timer_out <= timer_level;
    compare_pwm_out <= 1'b0;
    comparator2_out <= 1'b0;
  endtask
  // One transition on one line, launched just after an edge
  task automatic fire(input int line, input logic level);
    @(posedge clock);
    case (line)
      0: first_edge_pin <= level;
      1: first_timer_out <= level;
      2: compare_pwm_out <= level;
      3: second_edge_pin <= level;
      default: comparator2_out <= level;
    endcase
  endtask
endmodule

//--- dv/tb.sv
`timescale 1ns/10ps
module tb;
  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic first_edge_pin, second_edge_pin, first_timer_out, compare_pwm_out, comparator2_out;
  logic current_source_on, discharge_on, delay_pulse_out, adc_sample_start, irq_request;
  logic [1:0] current_range_sel;
  logic [5:0] current_trim;
  logic [7:0] cfg;
  int error_cnt = 0;
  int checks = 0;
  int adc_cnt = 0;
  int mdl [5] = '{default: 0};
  int k;

  always #20 clock = ~clock;
  // Count converter starts mid-cycle, clear of the rising edge at which the output changes
  always @(negedge clock) if (adc_sample_start === 1'b1) adc_cnt++;

  charge_time_unit charge_time_unit_inst (.clock, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .first_edge_pin, .second_edge_pin, .first_timer_out, .compare_pwm_out, .comparator2_out, .current_source_on,
    .current_range_sel, .current_trim, .discharge_on, .delay_pulse_out, .adc_sample_start, .irq_request);
  edge_partner edge_partner_inst (.clock, .first_edge_pin, .second_edge_pin, .first_timer_out, .compare_pwm_out,
    .comparator2_out);

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Register write; the model follows every mapped write
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    if (a < 3'h5) mdl[a] = d;
  endtask
  // Read compared with the model; the high register hides bits 6, 5 and 0
  task automatic rdc(input logic [2:0] a);
    logic [7:0] exp;
    exp = (a > 3'h4) ? 8'h00 : 8'(mdl[a]);
    if (a == 3'h2) exp = exp & 8'h9E;
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk("reg_rdata", reg_rdata, exp);
  endtask
  // Bounded wait for the source to match the model, then compare
  task automatic wait_src();
    logic exp;
    exp = mdl[2][7] & (mdl[1][0] ^ mdl[1][1]);
    for (int i = 0; i < 12 && current_source_on !== exp; i++) @(negedge clock);
    chk("current_source_on", {7'h0, current_source_on}, {7'h0, exp});
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #(40 * 5000);
    error_cnt++;
    print_verdict();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    k = $urandom(28);
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    // Everything reads zero after reset; unmapped offsets ignore writes
    for (int a = 0; a < 8; a++) rdc(a[2:0]);
    wr(3'h6, 8'hFF);
    rdc(3'h6);
    // Every range code with a random trim
    for (int i = 0; i < 4; i++) begin
      cfg = {6'($urandom), i[1:0]};
      wr(3'h0, cfg);
      rdc(3'h0);
      chk("range_trim", {current_trim, current_range_sel}, cfg);
    end
    wr(3'h1, 8'($urandom) & 8'hFC);
    rdc(3'h1);
    wr(3'h2, 8'h7F);
    rdc(3'h2);
    chk("discharge_on", {7'h0, discharge_on}, 8'h01);
    wr(3'h2, 8'h00);
    rdc(3'h2);
    chk("discharge_on", {7'h0, discharge_on}, 8'h00);
    // Init order, then one measurement per first-edge source code
    wr(3'h2, 8'h80);
    wr(3'h4, 8'h04);
    wr(3'h2, 8'h88);
    for (int s = 0; s < 4; s++) begin
      cfg = 8'h20 | ((s == 1 || s == 2) ? 8'h10 : 8'h00) | 8'(s << 2);
      // Disarm while lines and selections move, so a stray edge cannot set a flag
      wr(3'h2, 8'h80);
      edge_partner_inst.park(s != 1);
      wr(3'h1, cfg);
      wr(3'h3, 8'h00);
      wr(3'h2, 8'h88);
      k = adc_cnt;
      edge_partner_inst.fire(s, s == 1 || s == 2);
      mdl[1] = cfg | 8'h01;
      wait_src();
      rdc(3'h1);
      edge_partner_inst.fire(1, 1'b0);
      mdl[1] = cfg | 8'h03;
      mdl[3] = 4;
      wait_src();
      rdc(3'h3);
      chk("irq_request", {7'h0, irq_request}, 8'h01);
      chk("adc_starts", 8'(adc_cnt - k), 8'h01);
    end
    // Ordering on: a second edge ahead of the first is dropped
    cfg = 8'h34;
    edge_partner_inst.park(1'b1);
    wr(3'h2, 8'h8C);
    wr(3'h1, cfg);
    wr(3'h1, cfg);
    edge_partner_inst.fire(1, 1'b0);
    repeat (6) @(posedge clock);
    rdc(3'h1);
    edge_partner_inst.fire(1, 1'b1);
    mdl[1] = cfg | 8'h01;
    wait_src();
    edge_partner_inst.fire(1, 1'b0);
    mdl[1] = cfg | 8'h03;
    wait_src();
    // Edges disarmed: a valid first edge changes nothing
    wr(3'h2, 8'h80);
    wr(3'h1, cfg);
    edge_partner_inst.fire(1, 1'b1);
    repeat (6) @(posedge clock);
    rdc(3'h1);
    // Software sets one flag in delay mode; the unit enable gates it
    wr(3'h2, 8'h90);
    k = adc_cnt;
    wr(3'h1, cfg | 8'h01);
    mdl[1] = cfg | 8'h01;
    wait_src();
    chk("delay_pulse_out", {7'h0, delay_pulse_out}, 8'h01);
    wr(3'h2, 8'h10);
    wait_src();
    wr(3'h2, 8'h98);
    wait_src();
    // Comparator ends the delay pulse
    edge_partner_inst.fire(4, 1'b1);
    mdl[1] = cfg | 8'h03;
    wait_src();
    chk("delay_pulse_out", {7'h0, delay_pulse_out}, 8'h00);
    // Delay mode turn-offs must not start the converter
    repeat (2) @(negedge clock);
    chk("adc_starts", 8'(adc_cnt - k), 8'h00);
    print_verdict();
  end
endmodule
